// ---- rtl/eeprom_host.sv ----
`timescale 1ns/100ps
`include "eeprom_rd_poll_consts.svh"

module eeprom_host (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // command
   input wire logic cmdValid,
   input wire eeprom_pkg::hostOp_t cmdOp,
   input wire logic [2:0] cmdSel,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic [7:0] cmdLen,
   output logic cmdReady,
   // results
   output logic rdValid,
   output logic [7:0] rdData,
   output logic done,
   output logic nackErr,
   // bus
   eeprom_bus_if.host bus
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   eeprom_pkg::hostState_t st_q, st_d;
   eeprom_pkg::byteRole_t role_q, role_d;
   eeprom_pkg::hostOp_t op_q, op_d;
   logic [4:0] qc_q, qc_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] rx_q, rx_d;
   logic [7:0] left_q, left_d;
   logic [2:0] sel_q, sel_d;
   logic [7:0] addr_q, addr_d;
   logic [7:0] data_q, data_d;
   logic rdPhase_q, rdPhase_d;
   logic ack_q, ack_d;
   logic sclOe_q, sclOe_d;
   logic sdaOe_q, sdaOe_d;
   logic ready_q, ready_d;
   logic rdValid_q, rdValid_d;
   logic [7:0] rdData_q, rdData_d;
   logic done_q, done_d;
   logic nack_q, nack_d;
   logic s1_q;
   logic s2_q;
   logic tick;

   assign tick = qc_q == 5'(`HOST_QUARTER_CYC - 1);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      role_d = role_q;
      op_d = op_q;
      ph_d = ph_q;
      bit_d = bit_q;
      tx_d = tx_q;
      rx_d = rx_q;
      left_d = left_q;
      sel_d = sel_q;
      addr_d = addr_q;
      data_d = data_q;
      rdPhase_d = rdPhase_q;
      ack_d = ack_q;
      sclOe_d = sclOe_q;
      sdaOe_d = sdaOe_q;
      ready_d = ready_q;
      rdValid_d = 1'b0;
      rdData_d = rdData_q;
      done_d = 1'b0;
      nack_d = nack_q;
      qc_d = (tick || st_q == eeprom_pkg::H_IDLE) ? 5'h00 : qc_q + 5'h01;
      if (tick && st_q != eeprom_pkg::H_IDLE) begin
         ph_d = ph_q + 2'h1;
      end
      unique case (st_q)
         eeprom_pkg::H_IDLE: begin
            ready_d = 1'b1;
            ph_d = 2'h0;
            if (cmdValid && ready_q) begin
               ready_d = 1'b0;
               op_d = cmdOp;
               sel_d = cmdSel;
               addr_d = cmdAddr;
               data_d = cmdData;
               left_d = (cmdLen == 8'h00) ? 8'h01 : cmdLen;
               rdPhase_d = cmdOp == eeprom_pkg::OP_CUR_READ;
               nack_d = 1'b0;
               st_d = eeprom_pkg::H_START; // RULE3
            end
         end
         eeprom_pkg::H_START: begin
            if (tick) begin
               unique case (ph_q)
                  2'h0: sdaOe_d = 1'b0;
                  2'h1: sclOe_d = 1'b0;
                  2'h2: sdaOe_d = 1'b1;
                  2'h3: begin
                     sclOe_d = 1'b1;
                     st_d = eeprom_pkg::H_BIT;
                     bit_d = 4'h0;
                     role_d = eeprom_pkg::B_CTRL;
                     tx_d = {`CTRL_CODE, sel_q, rdPhase_q ? `RW_READ : `RW_WRITE}; // RULE6 RULE16
                  end
               endcase
            end
         end
         eeprom_pkg::H_BIT: begin
            if (tick) begin
               unique case (ph_q)
                  2'h0: begin
                     if (bit_q != `ACK_SLOT) begin
                        sdaOe_d = ~tx_q[7];
                        tx_d = {tx_q[6:0], 1'b1};
                     end else begin
                        sdaOe_d = role_q == eeprom_pkg::B_RECV && left_q > 8'h01; // RULE9 RULE13
                     end
                  end
                  2'h1: sclOe_d = 1'b0;
                  2'h2: begin
                     if (bit_q != `ACK_SLOT) begin
                        rx_d = {rx_q[6:0], s2_q};
                     end else begin
                        ack_d = ~s2_q;
                     end
                  end
                  2'h3: begin
                     sclOe_d = 1'b1;
                     bit_d = bit_q + 4'h1;
                     if (bit_q == `ACK_SLOT) begin
                        bit_d = 4'h0;
                        unique case (role_q)
                           eeprom_pkg::B_CTRL: begin
                              if (!ack_q) begin
                                 if (op_q == eeprom_pkg::OP_POLL) begin
                                    st_d = eeprom_pkg::H_START; // RULE4
                                 end else begin
                                    nack_d = 1'b1;
                                    st_d = eeprom_pkg::H_STOP;
                                 end
                              end else if (rdPhase_q) begin
                                 role_d = eeprom_pkg::B_RECV;
                                 tx_d = 8'hFF;
                              end else if (op_q == eeprom_pkg::OP_POLL) begin
                                 st_d = eeprom_pkg::H_STOP;
                              end else begin
                                 role_d = eeprom_pkg::B_ADDR;
                                 tx_d = addr_q;
                              end
                           end
                           eeprom_pkg::B_ADDR: begin
                              if (!ack_q) begin
                                 nack_d = 1'b1;
                                 st_d = eeprom_pkg::H_STOP;
                              end else if (op_q == eeprom_pkg::OP_RAND_READ) begin
                                 rdPhase_d = 1'b1;
                                 st_d = eeprom_pkg::H_START; // RULE10
                              end else begin
                                 role_d = eeprom_pkg::B_DATA;
                                 tx_d = data_q;
                              end
                           end
                           eeprom_pkg::B_DATA: begin
                              nack_d = ~ack_q;
                              st_d = eeprom_pkg::H_STOP;
                           end
                           eeprom_pkg::B_RECV: begin
                              rdValid_d = 1'b1;
                              rdData_d = rx_q;
                              if (left_q > 8'h01) begin
                                 left_d = left_q - 8'h01; // RULE13
                                 tx_d = 8'hFF;
                              end else begin
                                 st_d = eeprom_pkg::H_STOP; // RULE9
                              end
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         eeprom_pkg::H_STOP: begin
            if (tick) begin
               unique case (ph_q)
                  2'h0: sdaOe_d = 1'b1;
                  2'h1: sclOe_d = 1'b0;
                  2'h2: sdaOe_d = 1'b0;
                  2'h3: begin
                     st_d = eeprom_pkg::H_IDLE;
                     done_d = 1'b1;
                  end
               endcase
            end
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= eeprom_pkg::H_IDLE;
         role_q <= eeprom_pkg::B_CTRL;
         op_q <= eeprom_pkg::OP_POLL;
         qc_q <= 5'h00;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         tx_q <= 8'hFF;
         rx_q <= 8'h00;
         left_q <= 8'h01;
         sel_q <= 3'h0;
         addr_q <= 8'h00;
         data_q <= 8'h00;
         rdPhase_q <= 1'b0;
         ack_q <= 1'b0;
         sclOe_q <= 1'b0;
         sdaOe_q <= 1'b0;
         ready_q <= 1'b0;
         rdValid_q <= 1'b0;
         rdData_q <= 8'h00;
         done_q <= 1'b0;
         nack_q <= 1'b0;
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end else begin
         st_q <= st_d;
         role_q <= role_d;
         op_q <= op_d;
         qc_q <= qc_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         left_q <= left_d;
         sel_q <= sel_d;
         addr_q <= addr_d;
         data_q <= data_d;
         rdPhase_q <= rdPhase_d;
         ack_q <= ack_d;
         sclOe_q <= sclOe_d;
         sdaOe_q <= sdaOe_d;
         ready_q <= ready_d;
         rdValid_q <= rdValid_d;
         rdData_q <= rdData_d;
         done_q <= done_d;
         nack_q <= nack_d;
         s1_q <= bus.sdaLine;
         s2_q <= s1_q;
      end
   end

   assign cmdReady = ready_q;
   assign rdValid = rdValid_q;
   assign rdData = rdData_q;
   assign done = done_q;
   assign nackErr = nack_q;
   assign bus.sclHostO = 1'b0;
   assign bus.sclHostOe = sclOe_q;
   assign bus.sdaHostO = 1'b0;
   assign bus.sdaHostOe = sdaOe_q;
endmodule

// ---- inc/eeprom_rd_poll_consts.svh ----
`ifndef EEPROM_RD_POLL_CONSTS_SVH
`define EEPROM_RD_POLL_CONSTS_SVH
// control byte code in the upper nibble
`define CTRL_CODE 4'hA
// read/write bit values
`define RW_READ 1'b1
`define RW_WRITE 1'b0
// pointer value after reset
`define PTR_RESET 8'h00
// index of the acknowledge slot within a byte
`define ACK_SLOT 4'h8
// core clock period
`define CORE_CLK_NS 20
// self-timed write cycle length
`define WRITE_CYCLE_NS 1000000
// host bus clock quarter period
`define HOST_QUARTER_NS 200
`define HOST_QUARTER_CYC (`HOST_QUARTER_NS / `CORE_CLK_NS)
`endif

// ---- inc/eeprom_pkg.sv ----
package eeprom_pkg;
   typedef enum logic [3:0] {
      D_IDLE = 4'h0,
      D_CTRL = 4'h1,
      D_CTRL_ACK = 4'h2,
      D_ADDR = 4'h3,
      D_ADDR_ACK = 4'h4,
      D_WDATA = 4'h5,
      D_WDATA_ACK = 4'h6,
      D_RDATA = 4'h7,
      D_RACK = 4'h8
   } devState_t;
   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_START = 2'h1,
      H_BIT = 2'h2,
      H_STOP = 2'h3
   } hostState_t;
   typedef enum logic [1:0] {
      B_CTRL = 2'h0,
      B_ADDR = 2'h1,
      B_DATA = 2'h2,
      B_RECV = 2'h3
   } byteRole_t;
   typedef enum logic [1:0] {
      OP_POLL = 2'h0,
      OP_CUR_READ = 2'h1,
      OP_RAND_READ = 2'h2,
      OP_WRITE = 2'h3
   } hostOp_t;
endpackage

// ---- inc/eeprom_bus_if.sv ----
`timescale 1ns/100ps
interface eeprom_bus_if;
   logic sclHostO;
   logic sclHostOe;
   logic sdaHostO;
   logic sdaHostOe;
   logic sdaDevO;
   logic sdaDevOe;
   logic sclLine;
   logic sdaLine;
   // open-drain wires with pull-ups
   assign sclLine = ~(sclHostOe & ~sclHostO);
   assign sdaLine = ~((sdaHostOe & ~sdaHostO) | (sdaDevOe & ~sdaDevO));
   modport device (
      input sclLine,
      input sdaLine,
      output sdaDevO,
      output sdaDevOe
   );
   modport host (
      input sclLine,
      input sdaLine,
      output sclHostO,
      output sclHostOe,
      output sdaHostO,
      output sdaHostOe
   );
endinterface

// ---- rtl/eeprom_client.sv ----
`timescale 1ns/100ps
`include "eeprom_rd_poll_consts.svh"

// Behaviour
// RULE1: no acknowledge while write cycle runs
// RULE2: stop after write starts write cycle
// RULE3: host may poll right after stop
// RULE4: host repeats start and control until ack
// RULE5: acknowledge poll once write cycle done
// RULE6: read starts like write, rw bit one
// RULE7: pointer holds last address plus one
// RULE8: read control acked, byte sent from pointer
// RULE9: host nacks then stops, device releases
// RULE10: random read: address, repeated start, read
// RULE11: repeated start aborts write, keeps address
// RULE12: after random read pointer follows byte
// RULE13: host ack brings next sequential byte
// RULE14: pointer increments after each byte
// RULE15: pointer wraps from FF to 00
// RULE16: control code 1010, select bits match
// RULE17: on host nack release data line
// RULE18: eight-bit pointer kept across stops
// RULE19: start or stop resets bus machine
module eeprom_client #(
   parameter int WriteCycles = `WRITE_CYCLE_NS / `CORE_CLK_NS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // select straps
   input wire logic chipSelectBit0,
   input wire logic chipSelectBit1,
   input wire logic chipSelectBit2,
   // status
   output logic writeBusy,
   // bus
   eeprom_bus_if.device bus
);
   // ----------------------------------------
   // storage and state
   // ----------------------------------------
   logic [7:0] mem [256];
   logic [4:0] syn1_q;
   logic [4:0] syn2_q;
   logic sclP_q;
   logic sdaP_q;
   eeprom_pkg::devState_t state_q, state_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic rdMode_q, rdMode_d;
   logic wrPend_q, wrPend_d;
   logic [7:0] wrAddr_q, wrAddr_d;
   logic [7:0] wrData_q, wrData_d;
   logic [19:0] busyCnt_q, busyCnt_d;
   logic busy_q, busy_d;
   logic sdaOe_q, sdaOe_d;
   logic sdaO_q;
   logic memWe;
   logic loadByte;
   logic sclS;
   logic sdaS;
   logic [2:0] selS;
   logic startEv;
   logic stopEv;
   logic rise;
   logic fall;
   logic [7:0] memRd;

   // ----------------------------------------
   // line conditions
   // ----------------------------------------
   assign sclS = syn2_q[1];
   assign sdaS = syn2_q[0];
   assign selS = syn2_q[4:2];
   assign startEv = sclS & sclP_q & sdaP_q & ~sdaS;
   assign stopEv = sclS & sclP_q & ~sdaP_q & sdaS;
   assign rise = sclS & ~sclP_q;
   assign fall = ~sclS & sclP_q;
   assign memRd = mem[ptr_q];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      rdMode_d = rdMode_q;
      wrPend_d = wrPend_q;
      wrAddr_d = wrAddr_q;
      wrData_d = wrData_q;
      sdaOe_d = sdaOe_q;
      memWe = 1'b0;
      loadByte = 1'b0;
      busyCnt_d = busyCnt_q;
      if (busyCnt_q != 20'h00000) begin
         busyCnt_d = busyCnt_q - 20'h00001;
      end
      if (stopEv) begin
         state_d = eeprom_pkg::D_IDLE; // RULE19
         sdaOe_d = 1'b0;
         if (wrPend_q) begin
            memWe = 1'b1; // RULE2
            busyCnt_d = 20'(WriteCycles); // RULE2
            wrPend_d = 1'b0;
         end
      end else if (startEv) begin
         state_d = eeprom_pkg::D_CTRL; // RULE19
         bitCnt_d = 4'h0;
         sdaOe_d = 1'b0;
         wrPend_d = 1'b0; // RULE11
      end else begin
         unique case (state_q)
            eeprom_pkg::D_IDLE: begin
            end
            eeprom_pkg::D_CTRL, eeprom_pkg::D_ADDR, eeprom_pkg::D_WDATA: begin
               if (rise && bitCnt_q != `ACK_SLOT) begin
                  shift_d = {shift_q[6:0], sdaS};
                  bitCnt_d = bitCnt_q + 4'h1;
               end else if (fall && bitCnt_q == `ACK_SLOT) begin
                  bitCnt_d = 4'h0;
                  if (state_q == eeprom_pkg::D_CTRL) begin
                     if (shift_q[7:4] == `CTRL_CODE && shift_q[3:1] == selS // RULE16
                         && !busy_q) begin // RULE1
                        sdaOe_d = 1'b1; // RULE5
                        rdMode_d = shift_q[0]; // RULE6
                        state_d = eeprom_pkg::D_CTRL_ACK;
                     end else begin
                        state_d = eeprom_pkg::D_IDLE; // RULE1
                     end
                  end else if (state_q == eeprom_pkg::D_ADDR) begin
                     ptr_d = shift_q; // RULE11
                     sdaOe_d = 1'b1;
                     state_d = eeprom_pkg::D_ADDR_ACK;
                  end else begin
                     wrPend_d = 1'b1;
                     wrAddr_d = ptr_q;
                     wrData_d = shift_q;
                     ptr_d = ptr_q + 8'h01; // RULE14
                     sdaOe_d = 1'b1;
                     state_d = eeprom_pkg::D_WDATA_ACK;
                  end
               end
            end
            eeprom_pkg::D_CTRL_ACK: begin
               if (fall) begin
                  if (rdMode_q == `RW_READ) begin
                     loadByte = 1'b1; // RULE8
                  end else begin
                     sdaOe_d = 1'b0;
                     state_d = eeprom_pkg::D_ADDR;
                  end
               end
            end
            eeprom_pkg::D_ADDR_ACK, eeprom_pkg::D_WDATA_ACK: begin
               if (fall) begin
                  sdaOe_d = 1'b0;
                  state_d = eeprom_pkg::D_WDATA;
               end
            end
            eeprom_pkg::D_RDATA: begin
               if (fall) begin
                  if (bitCnt_q == `ACK_SLOT) begin
                     sdaOe_d = 1'b0;
                     bitCnt_d = 4'h0;
                     state_d = eeprom_pkg::D_RACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b1};
                     sdaOe_d = ~shift_q[6];
                     bitCnt_d = bitCnt_q + 4'h1;
                  end
               end
            end
            eeprom_pkg::D_RACK: begin
               if (rise) begin
                  if (sdaS) begin
                     state_d = eeprom_pkg::D_IDLE; // RULE17
                  end else begin
                     bitCnt_d = 4'h1;
                  end
               end else if (fall && bitCnt_q == 4'h1) begin
                  loadByte = 1'b1; // RULE13
               end
            end
            default: begin
               state_d = eeprom_pkg::D_IDLE;
            end
         endcase
         if (loadByte) begin
            shift_d = memRd; // RULE7
            ptr_d = ptr_q + 8'h01; // RULE14 RULE15 RULE12
            sdaOe_d = ~memRd[7];
            bitCnt_d = 4'h1;
            state_d = eeprom_pkg::D_RDATA;
         end
      end
      busy_d = busyCnt_d != 20'h00000;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         syn1_q <= 5'h1F;
         syn2_q <= 5'h1F;
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
         state_q <= eeprom_pkg::D_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= `PTR_RESET; // RULE18
         rdMode_q <= 1'b0;
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         wrData_q <= 8'h00;
         busyCnt_q <= 20'h00000;
         busy_q <= 1'b0;
         sdaOe_q <= 1'b0;
         sdaO_q <= 1'b0;
      end else begin
         syn1_q <= {chipSelectBit2, chipSelectBit1, chipSelectBit0, bus.sclLine, bus.sdaLine};
         syn2_q <= syn1_q;
         sclP_q <= sclS;
         sdaP_q <= sdaS;
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         rdMode_q <= rdMode_d;
         wrPend_q <= wrPend_d;
         wrAddr_q <= wrAddr_d;
         wrData_q <= wrData_d;
         busyCnt_q <= busyCnt_d;
         busy_q <= busy_d;
         sdaOe_q <= sdaOe_d; // RULE9
         sdaO_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // array write
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (memWe) begin
         mem[wrAddr_q] <= wrData_q;
      end
   end

   assign writeBusy = busy_q;
   assign bus.sdaDevO = sdaO_q;
   assign bus.sdaDevOe = sdaOe_q;
endmodule

// ---- verif/eeprom_bus_chk.sv ----
`timescale 1ns/100ps
module eeprom_bus_chk #(
   parameter int WriteCycles = 200
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // bus wires
   input wire logic sclHostO,
   input wire logic sclHostOe,
   input wire logic sdaHostO,
   input wire logic sdaHostOe,
   input wire logic sdaDevO,
   input wire logic sdaDevOe,
   input wire logic sclLine,
   input wire logic sdaLine,
   // status
   input wire logic writeBusy
);
   // ---------
   // busy count
   // ---------
   logic [31:0] busyCnt_q;
   logic [31:0] busyCnt_d;
   always_comb begin
      busyCnt_d = writeBusy ? busyCnt_q + 32'h1 : 32'h0;
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         busyCnt_q <= 32'h0;
      else
         busyCnt_q <= busyCnt_d;
   end
   // ---------
   // properties
   // ---------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_busy_no_ack: assert property (writeBusy |-> !sdaDevOe)
      else $error("device drives sda while busy");
   a_busy_after_stop: assert property ($rose(writeBusy) |-> sclLine && sdaLine && !$past(sdaLine, 6))
      else $error("write cycle began without stop");
   a_busy_length: assert property ($fell(writeBusy) |-> busyCnt_q == WriteCycles)
      else $error("write cycle length wrong");
   a_drive_at_low: assert property ($changed(sdaDevOe) |-> !sclLine)
      else $error("device sda changed while scl high");
   a_drive_latency: assert property ($rose(sdaDevOe) |-> !$past(sclLine, 2) && $past(sclLine, 7))
      else $error("device drive not after scl fall");
   a_release_late: assert property ($fell(sdaDevOe) |-> !$past(sclLine, 2) && $past(sclLine, 7))
      else $error("device release not after scl fall");
   a_release_hold: assert property ($fell(sdaDevOe) |=> !sdaDevOe [*8])
      else $error("device release glitch");
   a_stop_idle: assert property (sclLine && $rose(sdaLine) |=> !sdaDevOe [*8])
      else $error("device drives after stop");
endmodule

// ---- verif/test_eeprom_read_and_ack_poll.sv ----
`timescale 1ns/100ps
module test_eeprom_read_and_ack_poll;
   // ---------
   // signals
   // ---------
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmdValid = 1'b0;
   eeprom_pkg::hostOp_t cmdOp = eeprom_pkg::OP_POLL;
   logic [2:0] cmdSel = 3'h5;
   logic [7:0] cmdAddr = 8'h00;
   logic [7:0] cmdData = 8'h00;
   logic [7:0] cmdLen = 8'h01;
   logic cmdReady, rdValid, done, nackErr, writeBusy;
   logic [7:0] rdData;
   logic [7:0] rxQ[$];
   int error_cnt = 0;
   int total_checks = 0;
   int lastCycles = 0;
   // write cycle long enough that the first poll attempts are refused
   localparam int WriteCycles = 1000;
   always #10 core_clk = ~core_clk;
   eeprom_bus_if eeprom_bus_if_i();
   eeprom_client #(.WriteCycles(WriteCycles)) eeprom_client_i (.core_clk(core_clk),
      .rst_b(rst_b),
      .chipSelectBit0(1'b1), .chipSelectBit1(1'b0), .chipSelectBit2(1'b1),
      .writeBusy(writeBusy), .bus(eeprom_bus_if_i.device));
   eeprom_host eeprom_host_i (.core_clk(core_clk), .rst_b(rst_b), .cmdValid(cmdValid),
      .cmdOp(cmdOp), .cmdSel(cmdSel), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdLen(cmdLen),
      .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData), .done(done),
      .nackErr(nackErr), .bus(eeprom_bus_if_i.host));
   eeprom_bus_chk #(.WriteCycles(WriteCycles)) eeprom_bus_chk_i (.core_clk(core_clk),
      .rst_b(rst_b),
      .sclHostO(eeprom_bus_if_i.sclHostO), .sclHostOe(eeprom_bus_if_i.sclHostOe),
      .sdaHostO(eeprom_bus_if_i.sdaHostO), .sdaHostOe(eeprom_bus_if_i.sdaHostOe),
      .sdaDevO(eeprom_bus_if_i.sdaDevO), .sdaDevOe(eeprom_bus_if_i.sdaDevOe),
      .sclLine(eeprom_bus_if_i.sclLine), .sdaLine(eeprom_bus_if_i.sdaLine),
      .writeBusy(writeBusy));
   // ---------
   // helpers
   // ---------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task run_cmd(input eeprom_pkg::hostOp_t op, input logic [7:0] addr, dat, len);
      int n;
      rxQ.delete();
      @(negedge core_clk);
      cmdOp = op;
      cmdAddr = addr;
      cmdData = dat;
      cmdLen = len;
      cmdValid = 1'b1;
      n = 0;
      while (cmdReady !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 100) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cmdReady, 1'b1);
      end
      @(negedge core_clk);
      cmdValid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 4000) begin
         if (rdValid === 1'b1) rxQ.push_back(rdData);
         @(negedge core_clk);
         n++;
      end
      if (n == 4000) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, done, 1'b1);
      end
      lastCycles = n;
   endtask
   task write_poll(input logic [7:0] addr, dat);
      run_cmd(eeprom_pkg::OP_WRITE, addr, dat, 8'h01);
      chk({7'h0, writeBusy}, 8'h01);
      run_cmd(eeprom_pkg::OP_POLL, 8'h00, 8'h00, 8'h01);
      chk({7'h0, lastCycles >= WriteCycles}, 8'h01);
      chk({7'h0, nackErr}, 8'h00);
      chk({7'h0, writeBusy}, 8'h00);
   endtask
   // ---------
   // scenarios
   // ---------
   task t_write_poll;
      write_poll(8'hFE, 8'h5A);
      write_poll(8'hFF, 8'hA5);
      write_poll(8'h00, 8'h3C);
      $display("write and poll finished");
   endtask
   task t_random_read;
      run_cmd(eeprom_pkg::OP_RAND_READ, 8'hFE, 8'h00, 8'h01);
      chk(8'(rxQ.size()), 8'h01);
      chk(rxQ[0], 8'h5A);
      chk({7'h0, writeBusy}, 8'h00);
      $display("random read finished");
   endtask
   task t_current_read;
      run_cmd(eeprom_pkg::OP_CUR_READ, 8'h00, 8'h00, 8'h01);
      chk(rxQ[0], 8'hA5);
      run_cmd(eeprom_pkg::OP_CUR_READ, 8'h00, 8'h00, 8'h01);
      chk(rxQ[0], 8'h3C);
      chk({7'h0, nackErr}, 8'h00);
      $display("current read finished");
   endtask
   task t_seq_read;
      run_cmd(eeprom_pkg::OP_RAND_READ, 8'hFE, 8'h00, 8'h03);
      chk(8'(rxQ.size()), 8'h03);
      chk(rxQ[0], 8'h5A);
      chk(rxQ[1], 8'hA5);
      chk(rxQ[2], 8'h3C);
      run_cmd(eeprom_pkg::OP_RAND_READ, 8'hFF, 8'h00, 8'h01);
      run_cmd(eeprom_pkg::OP_CUR_READ, 8'h00, 8'h00, 8'h01);
      chk(rxQ[0], 8'h3C);
      $display("sequential read finished");
   endtask
   task t_wrong_select;
      cmdSel = 3'h4;
      run_cmd(eeprom_pkg::OP_CUR_READ, 8'h00, 8'h00, 8'h01);
      chk({7'h0, nackErr}, 8'h01);
      chk(8'(rxQ.size()), 8'h00);
      cmdSel = 3'h5;
      $display("wrong select finished");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
      t_write_poll();
      t_random_read();
      t_current_read();
      t_seq_read();
      t_wrong_select();
      complete_run();
   end
   initial begin
      #800000;
      error_cnt++;
      complete_run();
   end
endmodule
